// ===== hw/rfc_consts.vh
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH
// Register offsets inside one port, port index in address bits 11:9
`define RFC_OFS_MON 9'h012
`define RFC_OFS_SIG 9'h013
`define RFC_OFS_RX2 9'h014
`define RFC_OFS_BOC 9'h015
// Reset value shared by every register
`define RFC_RST_VAL 8'h00
// Writable bits of each register
`define RFC_MON_MASK 8'h1F
`define RFC_SIG_MASK 8'h17
`define RFC_RX2_MASK 8'h1F
`define RFC_BOC_MASK 8'hB6
// Signaling control fields
`define RFC_SIG_ONES 4
`define RFC_SIG_FFZ 2
`define RFC_SIG_FEN 1
`define RFC_SIG_INT 0
// T1 receive control fields
`define RFC_RX2_SLC 4
`define RFC_RX2_OOF_HI 3
`define RFC_RX2_OOF_LO 2
`define RFC_RX2_RAI 1
`define RFC_RX2_D4 0
// Bit-code control fields
`define RFC_BOC_RST 7
`define RFC_BOC_DIS_HI 5
`define RFC_BOC_DIS_LO 4
`define RFC_BOC_FLT_HI 2
`define RFC_BOC_FLT_LO 1
// Timing
`define RFC_CLK_MHZ 125
`define RFC_BOC_RST_US 250
`define RFC_BOC_RST_MAX (`RFC_BOC_RST_US * `RFC_CLK_MHZ)
`define RFC_BOC_RST_CYC 16'd32
`define RFC_RAI_MS 200
`define RFC_RAI_CYC (`RFC_RAI_MS * `RFC_CLK_MHZ * 1000)
// Counting thresholds
`define RFC_SIG_INT_MF 2'd3
`define RFC_RAI_CLR 5'd14
`define RFC_RAI_HIST 16'hFFFF
`endif

// ===== hw/rfc_rx_ctrl.v
// Notes on behaviour
// - Eight ports, register copy every 0x200
// - Five-bit selector picks monitored timeslot
// - T1 force ones on enabled channels
// - E1 resync after two bad alignment words
// - CAS mode also resyncs on zero timeslot
// - CAS mode alignment needs prior one
// - Force freeze overrides freeze enable
// - Freeze enable permits event freeze; off never
// - Integration reports after three stable multiframes
// - Control bit enables SLC-96 synchronizer
// - Two-bit out-of-frame criterion select
// - Alarm sets on sixteen 00FF patterns
// - Alarm clears at fourteen or fewer
// - Integrated alarm needs over 200ms persistence
// - D4 alarm select bit2 or frame12
// - Masked Sa changes raise status event
// - Reset bit self-clears within 250us
// - Filter settings apply after reset completes
// - Init done clears reset bit
// - Disintegration field sets clear count
// - Filter field sets validation count
// - Forced ones affect serial data only
`include "rfc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rfc_rx_ctrl #(
   parameter [31:0] RAI_INT_CYC = `RFC_RAI_CYC
) (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Register port
   input wire [11:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   // Global and per-port modes
   input wire init_done_i,
   input wire [7:0] t1_mode_i,
   input wire [7:0] esf_mode_i,
   // Line events, one bit per port; Sa values five bits per port
   input wire [7:0] fdl_stb_i,
   input wire [7:0] fdl_alarm_i,
   input wire [7:0] mfas_stb_i,
   input wire [7:0] mfas_err_i,
   input wire [7:0] ts16_zero_i,
   input wire [7:0] ts16_prev_one_i,
   input wire [7:0] mf_tick_i,
   input wire [7:0] sig_chg_i,
   input wire [7:0] freeze_evt_i,
   input wire [7:0] sa_stb_i,
   input wire [39:0] sa_bits_i,
   // Control levels, per port
   output wire [39:0] monitor_sel_o,
   output wire [7:0] sig_ones_en_o,
   output wire [7:0] sig_freeze_o,
   output wire [7:0] slc_sync_en_o,
   output wire [15:0] frame_loss_sel_o,
   output wire [7:0] d4_alarm_sel_o,
   output wire [15:0] boc_filter_o,
   output wire [15:0] boc_disint_o,
   output wire [7:0] boc_busy_o,
   // Status, per port
   output wire [7:0] remote_alarm_o,
   output wire [7:0] sig_report_o,
   output wire [7:0] mf_resync_o,
   output wire [7:0] mf_align_o,
   output wire [7:0] sa_change_o
);

   // ****************************************
   // Helpers
   // ****************************************
   // The alarm history is short, so a plain
   // adder chain is cheap enough here.
   // A tree would only matter if the history
   // were made much longer.
   // Count of ones in the alarm history
   function [4:0] rfc_pop;
      input [15:0] v;
      integer k;
      begin
         rfc_pop = 5'd0;
         for (k = 0; k < 16; k = k + 1) begin
            rfc_pop = rfc_pop + {4'd0, v[k]};
         end
      end
   endfunction

   localparam [24:0] RAI_N = RAI_INT_CYC[24:0];

   wire [63:0] prd; // Read values of all ports
   wire [8:0] off = addr_i[8:0]; // Offset inside port

   // ****************************************
   // Read data, one cycle after the strobe
   // ****************************************
   // Data stand for exactly one cycle and
   // return to zero, so a late sample by the
   // host reads zero rather than stale data.
   // The port index in the upper address
   // bits picks one slice of the read bus.
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= prd[{addr_i[11:9], 3'b000} +: 8];
      end else begin
         rdata_o <= 8'h00;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : port
         // ****************************************
         // Per-port registers
         // ****************************************
         wire we = wr_i & (addr_i[11:9] == g);
         wire t1 = t1_mode_i[g]; // T1 or E1 framing
         reg [7:0] mon_q; // Monitor select
         reg [7:0] sig_q; // Signaling control
         reg [7:0] t1c_q; // T1 receive control
         reg [7:0] sam_q; // Sa change masks
         reg [7:0] boc_q; // Bit-code control
         reg [1:0] flt_q; // Applied filter
         reg [1:0] dis_q; // Applied disintegration
         reg [15:0] bcnt_q; // Reset progress
         reg [7:0] rv; // Read value
         wire boc_done;
         wire boc_keep;

         assign boc_done = boc_q[`RFC_BOC_RST] &
            (bcnt_q == `RFC_BOC_RST_CYC - 16'd1);
         // Pending reset survives a write of zero
         assign boc_keep = boc_q[`RFC_BOC_RST] & ~boc_done & ~init_done_i;

         // Register writes
         // Reserved bits are masked on entry so
         // that they always read back as zero.
         // The shared offset keeps two separate
         // copies; a change of framing mode does
         // not lose the other mode's settings.
         // The reset bit of the bit-code control
         // cannot be cancelled by software once
         // it has been set.
         always @(posedge clk_i) begin
            if (!nrst_i) begin
               mon_q <= `RFC_RST_VAL;
               sig_q <= `RFC_RST_VAL;
               t1c_q <= `RFC_RST_VAL;
               sam_q <= `RFC_RST_VAL;
               boc_q <= `RFC_RST_VAL;
            end else begin
               if (we && off == `RFC_OFS_MON) begin
                  mon_q <= wdata_i & `RFC_MON_MASK;
               end
               if (we && off == `RFC_OFS_SIG) begin
                  sig_q <= wdata_i & `RFC_SIG_MASK;
               end
               // Shared offset steered by framing mode
               if (we && off == `RFC_OFS_RX2 && t1) begin
                  t1c_q <= wdata_i & `RFC_RX2_MASK;
               end
               if (we && off == `RFC_OFS_RX2 && !t1) begin
                  sam_q <= wdata_i & `RFC_RX2_MASK;
               end
               if (we && off == `RFC_OFS_BOC) begin
                  // Set by software wins over any clear
                  boc_q <= (wdata_i & `RFC_BOC_MASK) |
                     {boc_keep, 7'h00};
               end else if (boc_done | init_done_i) begin
                  boc_q[`RFC_BOC_RST] <= 1'b0;
               end
            end
         end

         // Acknowledged reset of the bit-code receiver
         // The reset takes a fixed number of
         // cycles, far inside the allowed time.
         // Filter and clear counts are copied
         // only when the reset finishes, so a
         // half-written setting never reaches
         // the receiver.
         always @(posedge clk_i) begin
            if (!nrst_i) begin
               bcnt_q <= 16'd0;
               flt_q <= 2'b00;
               dis_q <= 2'b00;
            end else if (boc_done) begin
               bcnt_q <= 16'd0;
               // New settings take effect only now
               flt_q <= boc_q[`RFC_BOC_FLT_HI:`RFC_BOC_FLT_LO];
               dis_q <= boc_q[`RFC_BOC_DIS_HI:`RFC_BOC_DIS_LO];
            end else if (boc_q[`RFC_BOC_RST]) begin
               bcnt_q <= bcnt_q + 16'd1;
            end else begin
               bcnt_q <= 16'd0;
            end
         end

         // Read mux for this port
         always @* begin
            case (off)
               `RFC_OFS_MON: rv = mon_q;
               `RFC_OFS_SIG: rv = sig_q;
               `RFC_OFS_RX2: rv = t1 ? t1c_q : sam_q;
               `RFC_OFS_BOC: rv = boc_q;
               default: rv = 8'h00;
            endcase
         end
         assign prd[g*8 +: 8] = rv;

         // ****************************************
         // Control levels
         // ****************************************
         assign monitor_sel_o[g*5 +: 5] = mon_q[4:0];
         // Serial data only; signaling output untouched
         assign sig_ones_en_o[g] = t1 & sig_q[`RFC_SIG_ONES];
         assign sig_freeze_o[g] = sig_q[`RFC_SIG_FFZ] |
            (sig_q[`RFC_SIG_FEN] & freeze_evt_i[g]);
         assign slc_sync_en_o[g] = t1 & t1c_q[`RFC_RX2_SLC];
         assign frame_loss_sel_o[g*2 +: 2] =
            t1c_q[`RFC_RX2_OOF_HI:`RFC_RX2_OOF_LO];
         assign d4_alarm_sel_o[g] = t1c_q[`RFC_RX2_D4];
         assign boc_filter_o[g*2 +: 2] = flt_q;
         assign boc_disint_o[g*2 +: 2] = dis_q;
         assign boc_busy_o[g] = boc_q[`RFC_BOC_RST];

         // ****************************************
         // Remote alarm detection
         // ****************************************
         reg [15:0] hist_q; // Last sixteen link patterns
         reg raw_q; // Unintegrated alarm
         reg rai_q; // Reported alarm
         reg [24:0] rcnt_q; // Persistence counter
         wire integ = t1c_q[`RFC_RX2_RAI] & esf_mode_i[g];
         wire [15:0] hist_n = {hist_q[14:0], fdl_alarm_i[g]};

         always @(posedge clk_i) begin
            if (!nrst_i) begin
               hist_q <= 16'h0000;
               raw_q <= 1'b0;
            end else if (fdl_stb_i[g]) begin
               hist_q <= hist_n;
               if (hist_n == `RFC_RAI_HIST) begin
                  raw_q <= 1'b1;
               end else if (rfc_pop(hist_n) <= `RFC_RAI_CLR) begin
                  raw_q <= 1'b0;
               end
            end
         end

         // Integration over the persistence window
         // The counter restarts whenever the raw
         // state agrees with the reported one, so
         // short interruptions do not build up.
         // Without integration the raw state is
         // passed on one cycle later.
         // Integration needs extended framing on
         // the port as well as the control bit.
         // The window length is a parameter so
         // that tests can use a short one.
         always @(posedge clk_i) begin
            if (!nrst_i) begin
               rai_q <= 1'b0;
               rcnt_q <= 25'd0;
            end else if (!integ) begin
               rai_q <= raw_q;
               rcnt_q <= 25'd0;
            end else if (raw_q == rai_q) begin
               rcnt_q <= 25'd0;
            end else if (rcnt_q == RAI_N) begin
               rai_q <= raw_q;
               rcnt_q <= 25'd0;
            end else begin
               rcnt_q <= rcnt_q + 25'd1;
            end
         end
         assign remote_alarm_o[g] = rai_q;

         // ****************************************
         // E1 multiframe alignment
         // ****************************************
         // Only E1 framing uses these pulses;
         // in T1 the error history is held clear.
         // A resync also clears the history so
         // that one later bad word cannot fire
         // a second resync by itself.
         reg err1_q; // Previous alignment word bad
         reg rsy_q; // Resync pulse
         reg aln_q; // Alignment pulse
         wire cas_resync_mode = sig_q[`RFC_SIG_ONES];
         wire bad2 = mfas_stb_i[g] & mfas_err_i[g] & err1_q;
         wire zero16 = cas_resync_mode & mf_tick_i[g] & ts16_zero_i[g];

         always @(posedge clk_i) begin
            if (!nrst_i) begin
               err1_q <= 1'b0;
               rsy_q <= 1'b0;
               aln_q <= 1'b0;
            end else begin
               rsy_q <= !t1 & (bad2 | zero16);
               aln_q <= !t1 & mfas_stb_i[g] & !mfas_err_i[g] &
                  (!cas_resync_mode | ts16_prev_one_i[g]);
               if (t1 | bad2 | zero16) begin
                  err1_q <= 1'b0;
               end else if (mfas_stb_i[g]) begin
                  err1_q <= mfas_err_i[g];
               end
            end
         end
         assign mf_resync_o[g] = rsy_q;
         assign mf_align_o[g] = aln_q;

         // ****************************************
         // Signaling change reporting
         // ****************************************
         // With integration on, any new change
         // restarts the stability window, so a
         // flickering value is never reported.
         // Without it every change is reported.
         reg pend_q; // Change awaiting stability
         reg [1:0] stab_q; // Stable multiframes seen
         reg rep_q; // Report pulse
         wire sint = sig_q[`RFC_SIG_INT];

         always @(posedge clk_i) begin
            if (!nrst_i) begin
               pend_q <= 1'b0;
               stab_q <= 2'd0;
               rep_q <= 1'b0;
            end else if (sig_chg_i[g]) begin
               // New change restarts the window
               pend_q <= sint;
               stab_q <= 2'd0;
               rep_q <= !sint;
            end else if (pend_q && mf_tick_i[g]) begin
               stab_q <= stab_q + 2'd1;
               rep_q <= (stab_q + 2'd1 == `RFC_SIG_INT_MF);
               pend_q <= (stab_q + 2'd1 != `RFC_SIG_INT_MF);
            end else begin
               rep_q <= 1'b0;
            end
         end
         assign sig_report_o[g] = rep_q;

         // ****************************************
         // Sa bit change events
         // ****************************************
         // The last seen values are kept even for
         // masked bits, so unmasking later does
         // not raise an event for an old change.
         // Events are raised in E1 framing only.
         reg [4:0] sa_q; // Last Sa4..Sa8 values
         reg sac_q; // Change pulse
         wire [4:0] sa_n = sa_bits_i[g*5 +: 5];

         always @(posedge clk_i) begin
            if (!nrst_i) begin
               sa_q <= 5'd0;
               sac_q <= 1'b0;
            end else if (sa_stb_i[g]) begin
               sa_q <= sa_n;
               sac_q <= !t1 & (|((sa_n ^ sa_q) & sam_q[4:0]));
            end else begin
               sac_q <= 1'b0;
            end
         end
         assign sa_change_o[g] = sac_q;
      end
   endgenerate

endmodule // rfc_rx_ctrl
`default_nettype wire

// ===== verif/rfc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_line_model (
   // Clock
   input wire clk_i,
   // Event strobes: link, alignment, tick, Sa, change
   output logic [4:0] stb_o,
   // Qualifiers of the strobed event
   output logic [4:0] qual_o
);
   reg [4:0] stb_q = 5'h00; // One strobe per event kind
   reg [4:0] val_q = 5'h00; // Qualifier bits
   // Qualifiers show inverted junk outside the strobe
   assign stb_o = stb_q;
   assign qual_o = (|stb_q) ? val_q : ~val_q;
   // One event: strobe for one cycle
   task send(input int kind, input [4:0] v);
      begin
         @(posedge clk_i);
         stb_q <= 5'h01 << kind;
         val_q <= v;
         @(posedge clk_i);
         stb_q <= 5'h00;
      end
   endtask
endmodule // rfc_line_model
`default_nettype wire

// ===== verif/rfc_rx_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module rfc_rx_ctrl_props (
   // Clock and reset
   input wire clk_i,
   input wire nrst_i,
   // Register port
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   // Modes and line events
   input wire init_done_i,
   input wire [7:0] t1_mode_i,
   input wire [7:0] mfas_stb_i,
   input wire [7:0] mfas_err_i,
   input wire [7:0] ts16_zero_i,
   input wire [7:0] mf_tick_i,
   input wire [7:0] sig_chg_i,
   input wire [7:0] sa_stb_i,
   // Block results
   input wire [15:0] boc_filter_o,
   input wire [7:0] boc_busy_o,
   input wire [7:0] sig_report_o,
   input wire [7:0] mf_resync_o,
   input wire [7:0] mf_align_o,
   input wire [7:0] sa_change_o
);
   // ****************************************
   // Port 0 properties
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   // Bit-code reset raised
   sequence s_boc_start;
      $rose(boc_busy_o[0]);
   endsequence
   // Bit-code reset over in bounded time
   sequence s_boc_end;
      ##[1:40] !boc_busy_o[0];
   endsequence
   a_boc_self_clear: assert property (s_boc_start |-> s_boc_end)
      else $error("bit-code reset stuck");
   a_boc_apply_late: assert property (
      $changed(boc_filter_o[1:0]) |-> $past(boc_busy_o[0]))
      else $error("filter applied without reset");
   a_boc_init_clear: assert property (
      init_done_i && !wr_i |=> boc_busy_o == 8'h00)
      else $error("init done left reset pending");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside read slot");
   a_resync_cause: assert property (
      mf_resync_o[0] |-> $past(mfas_stb_i[0] & mfas_err_i[0] | mf_tick_i[0] & ts16_zero_i[0]))
      else $error("resync without cause");
   a_align_cause: assert property (
      mf_align_o[0] |-> $past(mfas_stb_i[0] & ~mfas_err_i[0]))
      else $error("alignment without good word");
   a_sa_cause: assert property (
      sa_change_o[0] |-> $past(sa_stb_i[0] & ~t1_mode_i[0]))
      else $error("Sa event without E1 strobe");
   a_report_cause: assert property (
      sig_report_o[0] |-> $past(sig_chg_i[0] | mf_tick_i[0]))
      else $error("signaling report without cause");
endmodule // rfc_rx_ctrl_props
bind rfc_rx_ctrl rfc_rx_ctrl_props u_props (
   .clk_i, .nrst_i, .wr_i, .rd_i, .rdata_o, .init_done_i, .t1_mode_i, .mfas_stb_i,
   .mfas_err_i, .ts16_zero_i, .mf_tick_i, .sig_chg_i, .sa_stb_i, .boc_filter_o,
   .boc_busy_o, .sig_report_o, .mf_resync_o, .mf_align_o, .sa_change_o
);
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rfc_consts.vh"
module tb_top;
   // ****************************************
   // Signals
   // ****************************************
   reg clk_i = 1'b0; // 8 ns clock
   reg nrst_i = 1'b0; // Active low reset
   reg [11:0] addr_i = 12'h000;
   reg [7:0] wdata_i = 8'h00;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg init_done_i = 1'b0;
   reg [7:0] t1_mode_i = 8'hFE; // Port 0 starts in E1
   reg [7:0] esf_mode_i = 8'hFF;
   reg [7:0] freeze_evt_i = 8'h00;
   wire [4:0] stb, qual; // Line model events
   wire [7:0] fdl_stb_i, fdl_alarm_i, mfas_stb_i, mfas_err_i, ts16_zero_i, ts16_prev_one_i;
   wire [7:0] mf_tick_i, sig_chg_i, sa_stb_i, rdata_o, sig_ones_en_o, sig_freeze_o;
   wire [7:0] slc_sync_en_o, d4_alarm_sel_o, boc_busy_o, remote_alarm_o, sig_report_o;
   wire [7:0] mf_resync_o, mf_align_o, sa_change_o;
   wire [39:0] sa_bits_i, monitor_sel_o;
   wire [15:0] frame_loss_sel_o, boc_filter_o, boc_disint_o;
   integer err_total = 0; // Mismatches
   integer checks_done = 0; // Comparisons
   integer ev [0:3]; // Pulses: resync, align, Sa, report
   integer i;
   localparam [15:0] FZ = 16'h9274; // Nibbles: ctrl 2:1, event, expected
   localparam [31:0] MSK = {`RFC_BOC_MASK, `RFC_RX2_MASK, `RFC_SIG_MASK, `RFC_MON_MASK};
   always #4 clk_i = ~clk_i;
   // Port 0 line events
   assign fdl_stb_i = {7'h00, stb[0]};
   assign fdl_alarm_i = {7'h00, qual[0]};
   assign mfas_stb_i = {7'h00, stb[1]};
   assign mfas_err_i = {7'h00, qual[0]};
   assign ts16_prev_one_i = {7'h00, qual[1]};
   assign mf_tick_i = {7'h00, stb[2]};
   assign ts16_zero_i = {7'h00, qual[0]};
   assign sa_stb_i = {7'h00, stb[3]};
   assign sa_bits_i = {35'h0, qual};
   assign sig_chg_i = {7'h00, stb[4]};
   rfc_rx_ctrl #(.RAI_INT_CYC(32'd20)) uut (
      .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .init_done_i,
      .t1_mode_i, .esf_mode_i, .fdl_stb_i, .fdl_alarm_i, .mfas_stb_i, .mfas_err_i,
      .ts16_zero_i, .ts16_prev_one_i, .mf_tick_i, .sig_chg_i, .freeze_evt_i, .sa_stb_i,
      .sa_bits_i, .monitor_sel_o, .sig_ones_en_o, .sig_freeze_o, .slc_sync_en_o,
      .frame_loss_sel_o, .d4_alarm_sel_o, .boc_filter_o, .boc_disint_o, .boc_busy_o,
      .remote_alarm_o, .sig_report_o, .mf_resync_o, .mf_align_o, .sa_change_o);
   rfc_line_model line (.clk_i, .stb_o(stb), .qual_o(qual));
   // Count port 0 result pulses
   // Outputs are unknown before the first reset edge, so count only out of reset
   always @(posedge clk_i) begin
      if (nrst_i) begin
         ev[0] <= ev[0] + mf_resync_o[0];
         ev[1] <= ev[1] + mf_align_o[0];
         ev[2] <= ev[2] + sa_change_o[0];
         ev[3] <= ev[3] + sig_report_o[0];
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr_reg(input [11:0] a, input [7:0] d);
      begin
         @(posedge clk_i);
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clk_i);
         wr_i <= 1'b0;
         #1;
      end
   endtask
   task rd_chk(input [11:0] a, input [7:0] e);
      begin
         @(posedge clk_i);
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clk_i);
         rd_i <= 1'b0;
         #1 chk(rdata_o, e);
      end
   endtask
   task ev_chk(input int k, input int n);
      begin
         repeat (2) @(posedge clk_i);
         #1 chk(ev[k], n);
      end
   endtask
   task alarm_chk(input int wait_cyc, input [0:0] e);
      begin
         repeat (wait_cyc) @(posedge clk_i);
         #1 chk(remote_alarm_o[0], e);
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", checks_done, err_total);
         if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      repeat (8000) @(posedge clk_i);
      err_total = err_total + 1;
      finish_test;
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      for (i = 0; i < 4; i = i + 1) ev[i] = 0;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
         rd_chk(12'h412 + i, 8'h00);
         wr_reg(12'h412 + i, 8'hFF);
         rd_chk(12'h412 + i, MSK[i*8 +: 8]);
      end
      chk(monitor_sel_o[14:10], 5'h1F);
      chk({sig_ones_en_o[2], slc_sync_en_o[2], d4_alarm_sel_o[2], sig_freeze_o[2]}, 4'hF);
      rd_chk(12'h612, 8'h00);
      wr_reg(12'h416, 8'hFF);
      rd_chk(12'h416, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         wr_reg(12'h414, {4'h0, i[1:0], 2'b00});
         chk(frame_loss_sel_o[5:4], i);
      end
      // E1 on port 0
      wr_reg(12'h014, 8'h10);
      line.send(3, 5'h01); ev_chk(2, 0);
      line.send(3, 5'h11); ev_chk(2, 1);
      line.send(1, 5'h01); line.send(1, 5'h01); ev_chk(0, 1);
      line.send(2, 5'h01); ev_chk(0, 1);
      wr_reg(12'h013, 8'h10);
      chk(sig_ones_en_o[0], 0);
      line.send(2, 5'h01); ev_chk(0, 2);
      line.send(1, 5'h00); ev_chk(1, 0);
      line.send(1, 5'h02); ev_chk(1, 1);
      wr_reg(12'h013, 8'h00);
      line.send(4, 5'h00); ev_chk(3, 1);
      wr_reg(12'h013, 8'h01);
      line.send(4, 5'h00); line.send(2, 5'h00); line.send(2, 5'h00); ev_chk(3, 1);
      line.send(2, 5'h00); ev_chk(3, 2);
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge clk_i) freeze_evt_i <= {7'h00, FZ[i*4+1]};
         wr_reg(12'h013, {5'h00, FZ[i*4+3 -: 2], 1'b0});
         chk(sig_freeze_o[0], FZ[i*4]);
      end
      // T1 on port 0
      @(posedge clk_i) t1_mode_i <= 8'hFF;
      rd_chk(12'h014, 8'h00);
      wr_reg(12'h013, 8'h10);
      chk(sig_ones_en_o[0], 1);
      for (i = 0; i < 4; i = i + 1) begin
         wr_reg(12'h015, {1'b1, 1'b0, i[1:0], 1'b0, i[1:0], 1'b0});
         chk({boc_busy_o[0], boc_filter_o[1:0]}, {1'b1, i[1:0] - 2'd1 + (i == 0)});
         repeat (34) @(posedge clk_i);
         #1 chk({boc_busy_o[0], boc_disint_o[1:0], boc_filter_o[1:0]}, {1'b0, i[1:0], i[1:0]});
         rd_chk(12'h015, {2'b00, i[1:0], 1'b0, i[1:0], 1'b0});
      end
      wr_reg(12'h015, 8'h12);
      repeat (34) @(posedge clk_i);
      #1 chk({boc_disint_o[1:0], boc_filter_o[1:0]}, 4'hF);
      wr_reg(12'h015, 8'h80);
      @(posedge clk_i) init_done_i <= 1'b1;
      @(posedge clk_i) init_done_i <= 1'b0;
      #1 chk(boc_busy_o[0], 0);
      repeat (15) line.send(0, 5'h01);
      alarm_chk(1, 0);
      line.send(0, 5'h01); alarm_chk(1, 1);
      line.send(0, 5'h00); alarm_chk(1, 1);
      line.send(0, 5'h00); alarm_chk(1, 0);
      wr_reg(12'h014, 8'h02);
      repeat (16) line.send(0, 5'h01);
      alarm_chk(3, 0);
      alarm_chk(30, 1);
      line.send(0, 5'h00); line.send(0, 5'h00); alarm_chk(3, 1);
      alarm_chk(30, 0);
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
